// *** include/sbst_pkg.sv ***
package sbst_pkg;
  // instruction register width and codes
  localparam int unsigned IR_W         = 3;
  localparam logic [2:0]  IR_EXTEST    = 3'h0;
  localparam logic [2:0]  IR_IDCODE    = 3'h1;
  localparam logic [2:0]  IR_SAMPLE_Z  = 3'h2;
  localparam logic [2:0]  IR_SAMPLE    = 3'h4;
  localparam logic [2:0]  IR_BYPASS    = 3'h7;
  localparam logic [2:0]  IR_CAPTURE   = 3'h1;  // fixed pattern loaded in capture-ir
  // boundary chain layout
  localparam int unsigned BSR_LEN      = 110;
  localparam int unsigned CTRL_BIT     = 109;
  localparam int unsigned DQ_W         = 36;
  localparam int unsigned ECHO_BIT     = 36;
  localparam int unsigned ECHO_N_BIT   = 37;
  localparam int unsigned RVALID_BIT   = 38;
  localparam int unsigned OUT_CELLS    = 39;
  localparam int unsigned IN_W         = 70;
  localparam int unsigned PAD_W        = 109;
  localparam logic        CTRL_RESET   = 1'b0;
  // identification word; value is arbitrary, bit 0 set as the standard requires
  localparam logic [31:0] ID_VALUE     = 32'h0ABC_D001;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001, ST_IDLE    = 16'h0002, ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008, ST_SH_DR   = 16'h0010, ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040, ST_EX2_DR  = 16'h0080, ST_UPD_DR  = 16'h0100,
    ST_SEL_IR  = 16'h0200, ST_CAP_IR  = 16'h0400, ST_SH_IR   = 16'h0800,
    ST_EX1_IR  = 16'h1000, ST_PAU_IR  = 16'h2000, ST_EX2_IR  = 16'h4000,
    ST_UPD_IR  = 16'h8000
  } sbst_state_e;
endpackage

// *** verilog/sbst_tap.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: three-bit instruction, five defined codes decoded
// R2: controller never loads codes 011, 101, 110
// R3: sample-z floats data pins, captures pad values
// R4: chain bit 109 steers output pin source
// R5: control bit loads only on update-dr, extest/sample
// R6: extest: echo/valid update; data follow control
// R7: idcode, sample, bypass: pins carry sram output
// R8: sample-z: echo, valid, data all float
// R9: extest, sample-z: output cells capture pad value
// R10: sample while reading: cells capture internal output
// R11: sample idle: echo/valid internal, data pad
// R12: controller holds dll disable high checking valid; no dll disable pin here, extest read-valid comes from its update cell
// R13: idcode/bypass output cell capture left undefined
// R14: instruction resets to idcode, also in reset state
// R15: bypass: one-bit register between tdi and tdo
module sbst_tap (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    tck,
  input  wire logic                    tms,
  input  wire logic                    tdi,
  output logic                         tdo,
  output logic                         tdo_oe_n,
  input  wire logic [sbst_pkg::DQ_W-1:0] sram_data,
  input  wire logic                    sram_echo_clock,
  input  wire logic                    sram_echo_clock_n,
  input  wire logic                    sram_read_valid,
  input  wire logic                    sram_reading,
  input  wire logic [sbst_pkg::DQ_W-1:0] data_pad_i,
  input  wire logic                    echo_clock_pad_i,
  input  wire logic                    echo_clock_n_pad_i,
  input  wire logic                    read_valid_pad_i,
  input  wire logic [sbst_pkg::IN_W-1:0] in_pins_i,
  output logic [sbst_pkg::DQ_W-1:0]    data_o,
  output logic                         data_oe_n,
  output logic                         echo_clock,
  output logic                         echo_clock_n,
  output logic                         read_valid_out,
  output logic                         echo_oe_n
);
  logic                             tck_s1, tck_s2, tck_s3, tck_q;
  logic                             tms_s1, tms_s2, tms_s3;
  logic                             tdi_s1, tdi_s2, tdi_s3;
  logic [sbst_pkg::PAD_W-1:0]       pad_s1, pad_s2, pad_s3;
  logic                             tck_rise, tck_fall;
  sbst_pkg::sbst_state_e            state_reg, state_next;
  logic [2:0]                       ir_shift_reg, ir_reg;
  logic [sbst_pkg::BSR_LEN-1:0]     bsr_shift_reg, bsr_upd_reg;
  logic [31:0]                      id_shift_reg;
  logic                             bypass_reg;
  logic [sbst_pkg::PAD_W-1:0]       cap_val;
  logic [sbst_pkg::OUT_CELLS-1:0]   int_val;
  logic                             ctrl_bit;
  logic                             is_extest, is_samplez, is_sample, is_bypass;

  // three-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2, tms_s3} <= 3'h7;
      {tdi_s1, tdi_s2, tdi_s3} <= 3'h7;
      pad_s1 <= '0;
      pad_s2 <= '0;
      pad_s3 <= '0;
    end else begin
      {tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
      {tms_s1, tms_s2, tms_s3} <= {tms, tms_s1, tms_s2};
      {tdi_s1, tdi_s2, tdi_s3} <= {tdi, tdi_s1, tdi_s2};
      pad_s1 <= {in_pins_i, read_valid_pad_i, echo_clock_n_pad_i, echo_clock_pad_i, data_pad_i};
      pad_s2 <= pad_s1;
      pad_s3 <= pad_s2;
    end
  end

  // filtered test clock level; edge counts only once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tck_q <= 1'b0;
    end else if (tck_s2 == tck_s3) begin
      tck_q <= tck_s3;
    end
  end

  assign tck_rise = (tck_s2 == tck_s3) && tck_s3 && !tck_q;
  assign tck_fall = (tck_s2 == tck_s3) && !tck_s3 && tck_q;

  // instruction decode; reserved codes fall to bypass-like behaviour [R1]
  assign is_extest  = (ir_reg == sbst_pkg::IR_EXTEST);
  assign is_samplez = (ir_reg == sbst_pkg::IR_SAMPLE_Z);
  assign is_sample  = (ir_reg == sbst_pkg::IR_SAMPLE);
  assign is_bypass  = (ir_reg == sbst_pkg::IR_BYPASS);
  assign ctrl_bit   = bsr_upd_reg[sbst_pkg::CTRL_BIT];
  assign int_val    = {sram_read_valid, sram_echo_clock_n, sram_echo_clock, sram_data};

  // tap controller next state
  always_comb begin
    case (state_reg)
      sbst_pkg::ST_RESET:  state_next = tms_s3 ? sbst_pkg::ST_RESET  : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_IDLE:   state_next = tms_s3 ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_DR: state_next = tms_s3 ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
      sbst_pkg::ST_CAP_DR: state_next = tms_s3 ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
      sbst_pkg::ST_SH_DR:  state_next = tms_s3 ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
      sbst_pkg::ST_EX1_DR: state_next = tms_s3 ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PAU_DR;
      sbst_pkg::ST_PAU_DR: state_next = tms_s3 ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PAU_DR;
      sbst_pkg::ST_EX2_DR: state_next = tms_s3 ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SH_DR;
      sbst_pkg::ST_UPD_DR: state_next = tms_s3 ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      sbst_pkg::ST_SEL_IR: state_next = tms_s3 ? sbst_pkg::ST_RESET  : sbst_pkg::ST_CAP_IR;
      sbst_pkg::ST_CAP_IR: state_next = tms_s3 ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
      sbst_pkg::ST_SH_IR:  state_next = tms_s3 ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
      sbst_pkg::ST_EX1_IR: state_next = tms_s3 ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PAU_IR;
      sbst_pkg::ST_PAU_IR: state_next = tms_s3 ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PAU_IR;
      sbst_pkg::ST_EX2_IR: state_next = tms_s3 ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SH_IR;
      sbst_pkg::ST_UPD_IR: state_next = tms_s3 ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
      default:             state_next = sbst_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= sbst_pkg::ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // instruction path; reserved codes are decoded but never meant to be loaded [R2]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ir_shift_reg <= sbst_pkg::IR_CAPTURE;
      ir_reg       <= sbst_pkg::IR_IDCODE;  // [R14]
    end else if (tck_rise) begin
      case (state_reg)
        sbst_pkg::ST_RESET:  ir_reg <= sbst_pkg::IR_IDCODE;  // [R14]
        sbst_pkg::ST_CAP_IR: ir_shift_reg <= sbst_pkg::IR_CAPTURE;
        sbst_pkg::ST_SH_IR:  ir_shift_reg <= {tdi_s3, ir_shift_reg[2:1]};
        sbst_pkg::ST_UPD_IR: ir_reg <= ir_shift_reg;  // [R1]
        default:             ir_reg <= ir_reg;
      endcase
    end
  end

  // capture source per cell: pads by default; under sample, echo/valid cells always and data cells while reading take internal output
  always_comb begin
    cap_val = pad_s3;  // [R3] [R9] [R13]
    if (is_sample) begin
      cap_val[sbst_pkg::RVALID_BIT:sbst_pkg::ECHO_BIT] =
        int_val[sbst_pkg::RVALID_BIT:sbst_pkg::ECHO_BIT];  // [R10] [R11]
      if (sram_reading) begin
        cap_val[sbst_pkg::DQ_W-1:0] = int_val[sbst_pkg::DQ_W-1:0];  // [R10]
      end
    end
  end

  // data registers; the control cell captures its own update value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bsr_shift_reg <= '0;
      id_shift_reg  <= sbst_pkg::ID_VALUE;
      bypass_reg    <= 1'b0;
    end else if (tck_rise && (state_reg == sbst_pkg::ST_CAP_DR)) begin
      bsr_shift_reg <= {ctrl_bit, cap_val};
      id_shift_reg  <= sbst_pkg::ID_VALUE;
      bypass_reg    <= 1'b0;
    end else if (tck_rise && (state_reg == sbst_pkg::ST_SH_DR)) begin
      bsr_shift_reg <= {tdi_s3, bsr_shift_reg[sbst_pkg::BSR_LEN-1:1]};
      id_shift_reg  <= {tdi_s3, id_shift_reg[31:1]};
      bypass_reg    <= tdi_s3;  // [R15]
    end
  end

  // update stage, loaded only under extest or sample/preload
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bsr_upd_reg <= {sbst_pkg::CTRL_RESET, {sbst_pkg::PAD_W{1'b0}}};
    end else if (tck_rise && (state_reg == sbst_pkg::ST_UPD_DR) && (is_extest || is_sample)) begin
      bsr_upd_reg <= bsr_shift_reg;  // [R5]
    end
  end

  // tdo changes on the falling test clock edge, driven only while shifting
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tdo      <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n <= !((state_reg == sbst_pkg::ST_SH_DR) || (state_reg == sbst_pkg::ST_SH_IR));
      if (state_reg == sbst_pkg::ST_SH_IR) begin
        tdo <= ir_shift_reg[0];
      end else if (is_extest || is_samplez || is_sample) begin
        tdo <= bsr_shift_reg[0];
      end else if (ir_reg == sbst_pkg::IR_IDCODE) begin
        tdo <= id_shift_reg[0];
      end else begin
        tdo <= bypass_reg;  // [R15]
      end
    end
  end

  // output pin source: update cells, sram output, or float [R4]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_o         <= '0;
      data_oe_n      <= 1'b1;
      echo_clock     <= 1'b0;
      echo_clock_n   <= 1'b0;
      read_valid_out <= 1'b0;
      echo_oe_n      <= 1'b1;
    end else if (is_extest) begin
      data_o         <= bsr_upd_reg[sbst_pkg::DQ_W-1:0];
      data_oe_n      <= !ctrl_bit;  // [R6]
      echo_clock     <= bsr_upd_reg[sbst_pkg::ECHO_BIT];  // [R6]
      echo_clock_n   <= bsr_upd_reg[sbst_pkg::ECHO_N_BIT];
      read_valid_out <= bsr_upd_reg[sbst_pkg::RVALID_BIT];
      echo_oe_n      <= 1'b0;
    end else if (is_samplez) begin
      data_oe_n      <= 1'b1;  // [R3] [R8]
      echo_oe_n      <= 1'b1;  // [R8]
    end else begin
      // sram drives data only while reading; echo clocks always run
      data_o         <= sram_data;  // [R7]
      data_oe_n      <= !sram_reading;
      echo_clock     <= sram_echo_clock;
      echo_clock_n   <= sram_echo_clock_n;
      read_valid_out <= sram_read_valid;
      echo_oe_n      <= 1'b0;
    end
  end

  // checks
  sequence seq_cap_dr;
    tck_rise && (state_reg == sbst_pkg::ST_CAP_DR);
  endsequence
  sequence seq_sample_cap;
    seq_cap_dr ##0 is_sample;
  endsequence

  AST_IR_RESET: assert property (@(posedge clk) disable iff (!resetn)  // [R14]
    tck_rise && (state_reg == sbst_pkg::ST_RESET) |=> ir_reg == sbst_pkg::IR_IDCODE)
    else $error("instruction not idcode after reset state");
  AST_EXTEST_FLOAT: assert property (@(posedge clk) disable iff (!resetn)  // [R6]
    is_extest && !ctrl_bit |=> data_oe_n && !echo_oe_n)
    else $error("extest with control low must float data only");
  AST_EXTEST_DRIVE: assert property (@(posedge clk) disable iff (!resetn)  // [R6]
    is_extest && ctrl_bit |=> !data_oe_n && (data_o == $past(bsr_upd_reg[35:0])))
    else $error("extest with control high must drive update data");
  AST_SAMPLEZ_FLOAT: assert property (@(posedge clk) disable iff (!resetn)  // [R8]
    is_samplez |=> data_oe_n && echo_oe_n)
    else $error("sample-z must float all outputs");
  AST_NORMAL_PATH: assert property (@(posedge clk) disable iff (!resetn)  // [R7]
    (is_sample || is_bypass || (ir_reg == sbst_pkg::IR_IDCODE))
    |=> (echo_clock == $past(sram_echo_clock)) && (read_valid_out == $past(sram_read_valid)))
    else $error("normal instruction must pass sram output");
  AST_CTRL_HOLD: assert property (@(posedge clk) disable iff (!resetn)  // [R5]
    !(tck_rise && (state_reg == sbst_pkg::ST_UPD_DR) && (is_extest || is_sample))
    |=> $stable(ctrl_bit))
    else $error("control bit changed outside update-dr");
  AST_SAMPLE_READ: assert property (@(posedge clk) disable iff (!resetn)  // [R10]
    seq_sample_cap ##0 sram_reading |=> bsr_shift_reg[35:0] == $past(sram_data))
    else $error("sample read must capture internal data");
  AST_SAMPLE_IDLE: assert property (@(posedge clk) disable iff (!resetn)  // [R11]
    seq_sample_cap ##0 !sram_reading
    |=> (bsr_shift_reg[35:0] == $past(pad_s3[35:0]))
        && (bsr_shift_reg[36] == $past(sram_echo_clock)))
    else $error("sample idle capture sources wrong");
  AST_PAD_CAPTURE: assert property (@(posedge clk) disable iff (!resetn)  // [R9]
    seq_cap_dr ##0 (is_extest || is_samplez) |=> bsr_shift_reg[38:0] == $past(pad_s3[38:0]))
    else $error("extest or sample-z must capture pads");
  AST_BYPASS_SHIFT: assert property (@(posedge clk) disable iff (!resetn)  // [R15]
    tck_fall && (state_reg == sbst_pkg::ST_SH_DR) && is_bypass |=> tdo == $past(bypass_reg))
    else $error("bypass bit not on tdo");
endmodule
`default_nettype wire

// *** tb/sbst_jtag_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural test controller; tck idles low between frames
module sbst_jtag_ctl (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // quiet levels at time zero
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one tck period of 8 clk; tdo is read late in the high phase, long after it settled
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'h1;
    repeat (4) @(posedge clk);
    o = tdo;
    tck <= 1'h0;
  endtask
  // off-shift steps toggle tdi so the device never leans on a stale level
  task automatic nav(input logic m);
    logic o;
    step(m, ~tdi, o);
  endtask
  // five ones reach test-logic-reset from any state, then park in idle
  task automatic tlr();
    repeat (5) nav(1'h1);
    nav(1'h0);
  endtask
  // from idle: scan n bits of the ir or dr path, lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic [127:0] d;
    d = din;
    if (ir && (d[2:0] == 3'h3 || d[2:0] == 3'h5 || d[2:0] == 3'h6))
      d[2:0] = sbst_pkg::IR_BYPASS;  // held-back codes never go out
    dout = 128'h0;
    nav(1'h1);
    if (ir)
      nav(1'h1);
    nav(1'h0);
    nav(1'h0);
    for (int i = 0; i < n; i++)
      step(i == n - 1, d[i], dout[i]);
    nav(1'h1);
    nav(1'h0);  // update happens on this rise
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         clk, resetn, tck, tms, tdi, tdo, tdo_oe_n, pin_req, word_v;
  logic         tdo_seen;
  logic [35:0]  sram_data, data_pad_i, data_o;
  logic         sram_echo_clock, sram_echo_clock_n, sram_read_valid, sram_reading;
  logic         echo_clock_pad_i, echo_clock_n_pad_i, read_valid_pad_i;
  logic [69:0]  in_pins_i;
  logic         data_oe_n, echo_clock, echo_clock_n, read_valid_out, echo_oe_n;
  logic [127:0] exp_q[$];
  logic [127:0] word, w, e, obs, p, q;
  logic [159:0] r;
  int           err_total, n_checks, cyc, seed;
  sbst_tap i_sbst_tap (
    .clk, .resetn, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .sram_data, .sram_echo_clock,
    .sram_echo_clock_n, .sram_read_valid, .sram_reading, .data_pad_i, .echo_clock_pad_i,
    .echo_clock_n_pad_i, .read_valid_pad_i, .in_pins_i, .data_o, .data_oe_n, .echo_clock,
    .echo_clock_n, .read_valid_out, .echo_oe_n
  );
  // a released tdo shows the inverse of its last level, so a read outside shifting fails
  assign tdo_seen = tdo_oe_n ? ~tdo : tdo;
  sbst_jtag_ctl i_sbst_jtag_ctl (.clk, .tck, .tms, .tdi, .tdo(tdo_seen));
  // 50 ns system clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // queue the expectation, then flag a scanned word or a pin snapshot
  task automatic note(input logic is_word, input logic [127:0] x, input logic [127:0] got);
    // pins are registered one edge after a new instruction or update lands
    @(posedge clk);
    exp_q.push_back(x);
    word <= got;
    word_v <= is_word;
    pin_req <= ~is_word;
    @(posedge clk);
    word_v <= 1'h0;
    pin_req <= 1'h0;
    @(posedge clk);
  endtask
  // oldest note against what appeared; floating pins carry no value worth comparing
  always @(posedge clk) begin
    if (word_v)
      chk(word, exp_q.pop_front());
    else if (pin_req) begin
      e = exp_q.pop_front();
      obs = {87'h0, echo_oe_n, read_valid_out, echo_clock_n, echo_clock, data_oe_n, data_o};
      if (e[36])
        obs[35:0] = 36'h0;
      if (e[40])
        obs[39:37] = 3'h0;
      chk(obs, e);
    end
  end
  // a hang is cut short well past the expected run of about 4900 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [127:0] sram_pins();
    return {87'h0, 1'h0, sram_read_valid, sram_echo_clock_n, sram_echo_clock, ~sram_reading,
            sram_reading ? sram_data : 36'h0};
  endfunction
  function automatic logic [127:0] upd_pins(input logic [127:0] u, input logic c);
    return {87'h0, 1'h0, u[38:36], ~c, c ? u[35:0] : 36'h0};
  endfunction
  // expected capture: data and echo cells from the pads or from the sram side
  function automatic logic [127:0] cap(input logic dint, input logic eint, input logic c);
    return {18'h0, c, in_pins_i,
            eint ? {sram_read_valid, sram_echo_clock_n, sram_echo_clock}
                 : {read_valid_pad_i, echo_clock_n_pad_i, echo_clock_pad_i},
            dint ? sram_data : data_pad_i};
  endfunction
  // fresh random levels on sram-side and pad inputs, held through the next scans
  task automatic rnd(input logic rd);
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    {sram_data, data_pad_i, in_pins_i, sram_echo_clock, sram_echo_clock_n, sram_read_valid,
     echo_clock_pad_i, echo_clock_n_pad_i, read_valid_pad_i} <= r[147:0];
    sram_reading <= rd;
    @(posedge clk);
  endtask
  task automatic ir(input logic [2:0] c);
    i_sbst_jtag_ctl.scan(1'h1, 3, {125'h0, c}, w);
  endtask
  // main sequence
  initial begin
    seed = 32'h0DFD65C4;
    err_total = 0;
    n_checks = 0;
    {resetn, pin_req, word_v, word, sram_reading} = 132'h0;
    {sram_data, data_pad_i, in_pins_i, sram_echo_clock, sram_echo_clock_n, sram_read_valid,
     echo_clock_pad_i, echo_clock_n_pad_i, read_valid_pad_i} = 148'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (8) @(posedge clk);
    rnd(1'h1);
    i_sbst_jtag_ctl.tlr();
    i_sbst_jtag_ctl.scan(1'h0, 32, 128'h0, w);
    note(1'h1, {96'h0, sbst_pkg::ID_VALUE}, w);
    note(1'h0, sram_pins(), 128'h0);
    ir(sbst_pkg::IR_BYPASS);
    note(1'h1, {125'h0, sbst_pkg::IR_CAPTURE}, w);
    i_sbst_jtag_ctl.scan(1'h0, 8, 128'hA5, w);
    note(1'h1, 128'h4A, w);
    note(1'h0, sram_pins(), 128'h0);
    ir(sbst_pkg::IR_SAMPLE);
    rnd(1'h0);
    p = {$random(seed), $random(seed), $random(seed), $random(seed)};
    p[127:109] = 19'h1;
    i_sbst_jtag_ctl.scan(1'h0, 110, p, w);
    note(1'h1, cap(1'h0, 1'h1, 1'h0), w);
    note(1'h0, sram_pins(), 128'h0);
    rnd(1'h1);
    i_sbst_jtag_ctl.scan(1'h0, 110, p, w);
    note(1'h1, cap(1'h1, 1'h1, 1'h1), w);
    ir(sbst_pkg::IR_EXTEST);
    // no dll disable pin reaches this block; read-valid comes from its update cell
    note(1'h0, upd_pins(p, 1'h1), 128'h0);
    q = {$random(seed), $random(seed), $random(seed), $random(seed)};
    q[127:109] = 19'h0;
    i_sbst_jtag_ctl.scan(1'h0, 110, q, w);
    note(1'h1, cap(1'h0, 1'h0, 1'h1), w);
    note(1'h0, upd_pins(q, 1'h0), 128'h0);
    ir(sbst_pkg::IR_SAMPLE_Z);
    note(1'h0, {87'h0, 1'h1, 3'h0, 1'h1, 36'h0}, 128'h0);
    i_sbst_jtag_ctl.scan(1'h0, 110, {q[127:110], 1'h1, q[108:0]}, w);
    note(1'h1, cap(1'h0, 1'h0, 1'h0), w);
    ir(sbst_pkg::IR_EXTEST);
    note(1'h0, upd_pins(q, 1'h0), 128'h0);
    i_sbst_jtag_ctl.tlr();
    i_sbst_jtag_ctl.scan(1'h0, 32, 128'h0, w);
    note(1'h1, {96'h0, sbst_pkg::ID_VALUE}, w);
    note(1'h0, sram_pins(), 128'h0);
    finish_test();
  end
endmodule
`default_nettype wire
